// ### rtl/identify_words_pkg.sv
package identify_words_pkg;

    // word indices inside the identification block
    localparam logic [7:0] OFS_FEAT_SUP_A   = 8'h52;
    localparam logic [7:0] OFS_FEAT_SUP_B   = 8'h53;
    localparam logic [7:0] OFS_FEAT_SUP_C   = 8'h54;
    localparam logic [7:0] OFS_FEAT_EN_A    = 8'h55;
    localparam logic [7:0] OFS_FEAT_EN_B    = 8'h56;
    localparam logic [7:0] OFS_FEAT_EN_C    = 8'h57;
    localparam logic [7:0] OFS_UDMA_MODES   = 8'h58;
    localparam logic [7:0] OFS_POWER_REQ    = 8'h A0;
    localparam logic [7:0] OFS_ADV_TIMING   = 8'hA3;

    // fixed ones of the feature words (bit 14 valid marker, fixed command support)
    localparam logic [15:0] FEAT_A_FIXED_ONE = 16'h7008;
    localparam logic [15:0] FEAT_B_FIXED_ONE = 16'h4004;
    localparam logic [15:0] FEAT_C_FIXED_ONE = 16'h4000;
    localparam logic [15:0] EN_B_FIXED_ONE   = 16'h0004;
    localparam logic [15:0] EN_C_FIXED_ONE   = 16'h4000;

    // variable bit positions of the feature words
    localparam int BIT_SMART     = 0;
    localparam int BIT_SECURITY  = 1;
    localparam int BIT_WCACHE    = 5;
    localparam int BIT_LOOKAHEAD = 6;
    localparam int BIT_APM       = 3;

    // indices into the feature enable vector
    localparam int FE_SMART     = 0;
    localparam int FE_SECURITY  = 1;
    localparam int FE_WCACHE    = 2;
    localparam int FE_LOOKAHEAD = 3;
    localparam int FE_APM       = 4;
    localparam int FE_L1_OFF    = 5;
    localparam int FE_COUNT     = 6;

    // ultra dma word layout
    localparam int UDMA_SEL_LSB = 8;
    localparam int UDMA_SUP_LSB = 0;
    localparam int UDMA_MODES   = 7;

    // power requirement word layout
    localparam int PWR_VALID_BIT = 15;
    localparam int PWR_RSVD_BIT  = 14;
    localparam int PWR_NO_L1_BIT = 13;
    localparam int PWR_L1_OFF_BIT = 12;
    localparam int PWR_CUR_LSB   = 0;
    localparam int PWR_CUR_W     = 12;

    // advanced timing word layout
    localparam int ADV_PIO_SUP_LSB  = 0;
    localparam int ADV_MDMA_SUP_LSB = 3;
    localparam int ADV_PIO_SEL_LSB  = 6;
    localparam int ADV_MDMA_SEL_LSB = 9;
    localparam int ADV_FIELD_W      = 3;
    localparam logic [2:0] ADV_PIO_BASE  = 3'h5;
    localparam logic [2:0] ADV_MDMA_BASE = 3'h3;

    // reset values of the held state
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic [5:0]  FEAT_EN_RST = 6'h00;
    localparam logic [15:0] DATA_RST    = 16'h0000;

    // kind of transfer mode carried by a mode selection
    typedef enum logic [1:0] {
        XFER_PIO,
        XFER_MDMA,
        XFER_UDMA
    } xfer_kind_t;

    // which dma family is currently selected
    typedef enum logic [1:0] {
        DMA_NONE,
        DMA_MULTI,
        DMA_ULTRA
    } dma_sel_t;

endpackage

// ### rtl/identify_capability_words.sv
// Behaviour
// - words 83 and 84 drive bit 14 one and bit 15 zero.
// - word 83 bits 5-13 and word 84 bits 0-13 carry no feature meaning.
// - word 82 bits 2,4,7,8,9,10 read zero.
// - word 82 bits 3,12,13,14 read one.
// - word 83 bits 0,1,4 zero, bit 2 one, bit 3 shows apm support.
// - word 87 bit 14 one, bit 15 zero; rest of 86/87 reserved.
// - word 85 bit 0 shows smart enable, host changeable, kept across power.
// - word 85 fixed bits match those of word 82.
// - word 86 bits 0,1,4 zero, bit 2 one, bit 3 apm enabled.
// - at most one dma mode selected; ultra and multiword exclude each other.
// - ultra dma word reads zero outside fixed-disk mode or without support.
// - ultra dma word bits 14-8 flag the selected mode, one hot.
// - ultra dma support bits 6-0 are cumulative downwards.
// - power word bit 15 marks valid description, bit 14 reads zero.
// - power word bits 13,12 level-one absent/disabled, bits 11-0 current mA.
// - timing word bits 2-0 code highest pio: 0 legacy, 1 mode5, 2 mode6.
// - timing word bits 5-3 code highest mdma: 0 legacy, 1 mode3, 2 mode4.
// - timing word bits 8-6 code selected pio mode alike.
// - timing word bits 11-9 code selected mdma mode; bits 15-12 reserved.
// - words are delivered as part of the identification data.
`timescale 1ns/10ps
`default_nettype none

module identify_capability_words #(
    parameter logic [5:0]  FEATURE_SUPPORT = 6'h3F,
    parameter logic        UDMA_SUPPORTED  = 1'b1,
    parameter logic [2:0]  MAX_UDMA_MODE   = 3'h4,
    parameter logic [2:0]  MAX_PIO_MODE    = 3'h6,
    parameter logic [2:0]  MAX_MDMA_MODE   = 3'h4,
    parameter logic        POWER_DESC_OK   = 1'b1,
    parameter logic        HAS_LEVEL_ONE   = 1'b1,
    parameter logic [11:0] MAX_CURRENT_MA  = 12'h064
) (
    // clock and reset
    input  wire logic                           i_clock,
    input  wire logic                           i_rst_n,
    // identification word read port
    input  wire logic                           i_word_rd,
    input  wire logic [7:0]                     i_word_index,
    output logic      [15:0]                    o_word_data,
    output logic                                o_word_valid,
    output logic                                o_word_mapped,
    // interface mode
    input  wire logic                           i_true_ide,
    // feature enable events from command execution
    input  wire logic [5:0]                     i_feat_set,
    input  wire logic [5:0]                     i_feat_clr,
    // nonvolatile smart enable, loaded after reset and saved back
    input  wire logic                           i_smart_saved,
    output logic                                o_smart_enabled,
    // transfer mode selection from set-features
    input  wire logic                           i_mode_sel,
    input  wire identify_words_pkg::xfer_kind_t i_mode_kind,
    input  wire logic [2:0]                     i_mode_num,
    output logic                                o_mode_reject
);

    typedef struct packed {
        logic [15:0]                  rdata;
        logic                         rvalid;
        logic                         rhit;
        logic [5:0]                   feat_en;
        logic                         smart_load;
        logic [2:0]                   pio_mode;
        logic [2:0]                   mdma_mode;
        logic [2:0]                   udma_mode;
        identify_words_pkg::dma_sel_t dma_sel;
        logic                         mode_rej;
    } state_t;

    state_t state_ff;
    state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // advanced mode code: 0 defers to the legacy word, then 1, 2 per mode
    function automatic logic [2:0] adv_code(input logic [2:0] mode, input logic [2:0] base);
        logic [2:0] code;
        code = 3'h0;
        if (mode >= base) begin
            code = 3'(mode - base + 3'h1);
        end
        return code;
    endfunction

    // cumulative support mask: modes 0..max all set
    function automatic logic [6:0] support_mask(input logic [2:0] max_mode);
        logic [6:0] mask;
        mask = 7'h00;
        for (int i = 0; i < identify_words_pkg::UDMA_MODES; i++) begin
            if (3'(i) <= max_mode) begin
                mask[i] = 1'b1;
            end
        end
        return mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // word images

    logic [15:0] w_sup_a;
    logic [15:0] w_sup_b;
    logic [15:0] w_sup_c;
    logic [15:0] w_en_a;
    logic [15:0] w_en_b;
    logic [15:0] w_en_c;
    logic [15:0] w_udma;
    logic [15:0] w_power;
    logic [15:0] w_timing;
    logic [5:0]  feat_live;

    // an enable only counts in the word images where the product supports the feature
    assign feat_live = state_ff.feat_en & FEATURE_SUPPORT;

    // supported word a: fixed ones, product support bits, zeros elsewhere
    always_comb begin
        w_sup_a = identify_words_pkg::FEAT_A_FIXED_ONE;
        w_sup_a[identify_words_pkg::BIT_SMART]     = FEATURE_SUPPORT[identify_words_pkg::FE_SMART];
        w_sup_a[identify_words_pkg::BIT_SECURITY]  = FEATURE_SUPPORT[identify_words_pkg::FE_SECURITY];
        w_sup_a[identify_words_pkg::BIT_WCACHE]    = FEATURE_SUPPORT[identify_words_pkg::FE_WCACHE];
        w_sup_a[identify_words_pkg::BIT_LOOKAHEAD] = FEATURE_SUPPORT[identify_words_pkg::FE_LOOKAHEAD];
    end

    // supported words b and c
    always_comb begin
        w_sup_b = identify_words_pkg::FEAT_B_FIXED_ONE;
        w_sup_b[identify_words_pkg::BIT_APM] = FEATURE_SUPPORT[identify_words_pkg::FE_APM];
        w_sup_c = identify_words_pkg::FEAT_C_FIXED_ONE;
    end

    // enabled words mirror the supported ones with live enables, but word b leaves bit 14 zero
    always_comb begin
        w_en_a = identify_words_pkg::FEAT_A_FIXED_ONE;
        w_en_a[identify_words_pkg::BIT_SMART]     = feat_live[identify_words_pkg::FE_SMART];
        w_en_a[identify_words_pkg::BIT_SECURITY]  = feat_live[identify_words_pkg::FE_SECURITY];
        w_en_a[identify_words_pkg::BIT_WCACHE]    = feat_live[identify_words_pkg::FE_WCACHE];
        w_en_a[identify_words_pkg::BIT_LOOKAHEAD] = feat_live[identify_words_pkg::FE_LOOKAHEAD];
        w_en_b = identify_words_pkg::EN_B_FIXED_ONE;
        w_en_b[identify_words_pkg::BIT_APM] = feat_live[identify_words_pkg::FE_APM];
        w_en_c = identify_words_pkg::EN_C_FIXED_ONE;
    end

    // ultra dma word
    always_comb begin
        w_udma = 16'h0000;
        if (i_true_ide && UDMA_SUPPORTED) begin
            w_udma[identify_words_pkg::UDMA_SUP_LSB +: 7] = support_mask(MAX_UDMA_MODE);
            if (state_ff.dma_sel == identify_words_pkg::DMA_ULTRA) begin
                w_udma[identify_words_pkg::UDMA_SEL_LSB +: 7] = 7'(7'h01 << state_ff.udma_mode);
            end
        end
    end

    // power requirement word, built from product constants and the live level-one disable enable
    always_comb begin
        w_power = 16'h0000;
        w_power[identify_words_pkg::PWR_VALID_BIT] = POWER_DESC_OK;
        w_power[identify_words_pkg::PWR_RSVD_BIT]  = 1'b0;
        w_power[identify_words_pkg::PWR_NO_L1_BIT]  = ~HAS_LEVEL_ONE;
        w_power[identify_words_pkg::PWR_L1_OFF_BIT] = HAS_LEVEL_ONE & feat_live[identify_words_pkg::FE_L1_OFF];
        w_power[identify_words_pkg::PWR_CUR_LSB +: identify_words_pkg::PWR_CUR_W] = MAX_CURRENT_MA;
    end

    // advanced timing word; upper nibble stays zero
    always_comb begin
        w_timing = 16'h0000;
        w_timing[identify_words_pkg::ADV_PIO_SUP_LSB +: identify_words_pkg::ADV_FIELD_W] =
            adv_code(MAX_PIO_MODE, identify_words_pkg::ADV_PIO_BASE);
        w_timing[identify_words_pkg::ADV_MDMA_SUP_LSB +: identify_words_pkg::ADV_FIELD_W] =
            adv_code(MAX_MDMA_MODE, identify_words_pkg::ADV_MDMA_BASE);
        w_timing[identify_words_pkg::ADV_PIO_SEL_LSB +: identify_words_pkg::ADV_FIELD_W] =
            adv_code(state_ff.pio_mode, identify_words_pkg::ADV_PIO_BASE);
        // selected mdma code, only while multiword is the dma family
        if (state_ff.dma_sel == identify_words_pkg::DMA_MULTI) begin
            w_timing[identify_words_pkg::ADV_MDMA_SEL_LSB +: identify_words_pkg::ADV_FIELD_W] =
                adv_code(state_ff.mdma_mode, identify_words_pkg::ADV_MDMA_BASE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic mode_ok;

    // a selection beyond what the product offers is refused, state kept
    always_comb begin
        mode_ok = 1'b0;
        unique case (i_mode_kind)
            identify_words_pkg::XFER_PIO:  mode_ok = (i_mode_num <= MAX_PIO_MODE);
            identify_words_pkg::XFER_MDMA: mode_ok = (i_mode_num <= MAX_MDMA_MODE);
            identify_words_pkg::XFER_UDMA: mode_ok = UDMA_SUPPORTED && i_true_ide && (i_mode_num <= MAX_UDMA_MODE);
            default:                       mode_ok = 1'b0;
        endcase
    end

    always_comb begin
        nxt_state          = state_ff;
        nxt_state.rvalid   = 1'b0;
        nxt_state.mode_rej = 1'b0;

        // set wins over a clear in the same cycle
        nxt_state.feat_en = (state_ff.feat_en & ~i_feat_clr) | i_feat_set;

        // smart enable restored from saved copy, not a default
        nxt_state.smart_load = 1'b0;
        if (state_ff.smart_load) begin
            nxt_state.feat_en[identify_words_pkg::FE_SMART] = i_smart_saved | i_feat_set[identify_words_pkg::FE_SMART];
        end

        // one dma family at a time
        if (i_mode_sel) begin
            if (!mode_ok) begin
                nxt_state.mode_rej = 1'b1;
            end else begin
                unique case (i_mode_kind)
                    identify_words_pkg::XFER_PIO: begin
                        nxt_state.pio_mode = i_mode_num;
                    end
                    identify_words_pkg::XFER_MDMA: begin
                        nxt_state.mdma_mode = i_mode_num;
                        nxt_state.dma_sel   = identify_words_pkg::DMA_MULTI;
                    end
                    identify_words_pkg::XFER_UDMA: begin
                        nxt_state.udma_mode = i_mode_num;
                        nxt_state.dma_sel   = identify_words_pkg::DMA_ULTRA;
                    end
                    default: begin
                        nxt_state.mode_rej = 1'b1;
                    end
                endcase
            end
        end

        // word delivered on an identification read
        if (i_word_rd) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rhit   = 1'b1;
            // feature words never read all zeros or all ones
            // unmapped and reserved positions read zero
            unique case (i_word_index)
                identify_words_pkg::OFS_FEAT_SUP_A: nxt_state.rdata = w_sup_a;
                identify_words_pkg::OFS_FEAT_SUP_B: nxt_state.rdata = w_sup_b;
                identify_words_pkg::OFS_FEAT_SUP_C: nxt_state.rdata = w_sup_c;
                identify_words_pkg::OFS_FEAT_EN_A:  nxt_state.rdata = w_en_a;
                identify_words_pkg::OFS_FEAT_EN_B:  nxt_state.rdata = w_en_b;
                identify_words_pkg::OFS_FEAT_EN_C:  nxt_state.rdata = w_en_c;
                identify_words_pkg::OFS_UDMA_MODES: nxt_state.rdata = w_udma;
                identify_words_pkg::OFS_POWER_REQ:  nxt_state.rdata = w_power;
                identify_words_pkg::OFS_ADV_TIMING: nxt_state.rdata = w_timing;
                default: begin
                    nxt_state.rdata = identify_words_pkg::DATA_RST;
                    nxt_state.rhit  = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // reset loads constants only; the saved smart bit is taken one edge later
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_ff.rdata      <= identify_words_pkg::DATA_RST;
            state_ff.rvalid     <= 1'b0;
            state_ff.rhit       <= 1'b0;
            state_ff.feat_en    <= identify_words_pkg::FEAT_EN_RST;
            state_ff.smart_load <= 1'b1;
            state_ff.pio_mode   <= identify_words_pkg::MODE_RST;
            state_ff.mdma_mode  <= identify_words_pkg::MODE_RST;
            state_ff.udma_mode  <= identify_words_pkg::MODE_RST;
            state_ff.dma_sel    <= identify_words_pkg::DMA_NONE;
            state_ff.mode_rej   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_word_data     = state_ff.rdata;
    assign o_word_valid    = state_ff.rvalid;
    assign o_word_mapped   = state_ff.rhit;
    assign o_smart_enabled = state_ff.feat_en[identify_words_pkg::FE_SMART];
    assign o_mode_reject   = state_ff.mode_rej;

endmodule

`default_nettype wire

// ### bench/identify_capability_words_assertions.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// watches the identify word port from the top module's pins only
module identify_words_checker #(
    parameter logic [2:0] MAX_UDMA_MODE  = 3'h4,
    parameter logic [2:0] MAX_MDMA_MODE  = 3'h4,
    parameter logic       UDMA_SUPPORTED = 1'b1
) (
    // clock and reset
    input wire logic                           i_clock,
    input wire logic                           i_rst_n,
    // read port
    input wire logic                           i_word_rd,
    input wire logic [7:0]                     i_word_index,
    input wire logic [15:0]                    o_word_data,
    input wire logic                           o_word_valid,
    input wire logic                           o_word_mapped,
    // control side
    input wire logic                           i_true_ide,
    input wire logic [5:0]                     i_feat_set,
    input wire logic [5:0]                     i_feat_clr,
    input wire logic                           i_smart_saved,
    input wire logic                           o_smart_enabled,
    input wire logic                           i_mode_sel,
    input wire identify_words_pkg::xfer_kind_t i_mode_kind,
    input wire logic [2:0]                     i_mode_num,
    input wire logic                           o_mode_reject
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // a taken read and its answer one cycle later
    sequence s_rd(logic [7:0] ix);
        i_word_rd && i_word_index == ix ##1 o_word_valid;
    endsequence
    // selections the device has to accept
    sequence s_udma_pick;
        i_mode_sel && i_mode_kind == identify_words_pkg::XFER_UDMA && i_true_ide && UDMA_SUPPORTED
            && i_mode_num <= MAX_UDMA_MODE;
    endsequence
    sequence s_mdma_pick;
        i_mode_sel && i_mode_kind == identify_words_pkg::XFER_MDMA && i_mode_num <= MAX_MDMA_MODE;
    endsequence

    a_valid_after_rd: assert property (i_word_rd |=> o_word_valid)
        else $error("read not answered next cycle");
    a_valid_no_rd: assert property (!i_word_rd |=> !o_word_valid)
        else $error("answer without a read");
    a_sup_a_fixed: assert property (s_rd(8'h52) |-> (o_word_data & 16'hFF9C) == 16'h7008)
        else $error("supported word a fixed bits wrong");
    a_sup_b_fixed: assert property (s_rd(8'h53) |-> (o_word_data & 16'hFFF7) == 16'h4004)
        else $error("supported word b fixed bits wrong");
    a_sup_c_fixed: assert property (s_rd(8'h54) |-> o_word_data == 16'h4000)
        else $error("supported word c wrong");
    a_en_c_fixed: assert property (s_rd(8'h57) |-> o_word_data == 16'h4000)
        else $error("enabled word c wrong");
    a_en_a_fixed: assert property (s_rd(8'h55) |-> (o_word_data & 16'hFF9C) == 16'h7008)
        else $error("enabled word a fixed bits wrong");
    a_en_b_fixed: assert property (s_rd(8'h56) |-> (o_word_data & 16'hFFF7) == 16'h0004)
        else $error("enabled word b fixed bits wrong");
    a_udma_off: assert property (i_word_rd && i_word_index == 8'h58 && !i_true_ide ##1 o_word_valid
        |-> o_word_data == 16'h0000) else $error("ultra word not zero outside fixed disk");
    a_udma_shape: assert property (s_rd(8'h58) |-> $onehot0(o_word_data[14:8]) && !o_word_data[15]
        && !o_word_data[7] && ((o_word_data[6:0] + 7'h01) & o_word_data[6:0]) == 7'h00)
        else $error("ultra word shape wrong");
    a_udma_excl: assert property (s_udma_pick ##2 s_rd(8'hA3) |-> o_word_data[11:9] == 3'h0)
        else $error("multiword still selected beside ultra");
    a_mdma_excl: assert property (s_mdma_pick ##2 s_rd(8'h58) |-> o_word_data[14:8] == 7'h00)
        else $error("ultra still selected beside multiword");
    a_power_rsvd: assert property (s_rd(8'hA0) |-> !o_word_data[14])
        else $error("power word reserved bit set");
    a_adv_codes: assert property (s_rd(8'hA3) |-> o_word_data[15:12] == 4'h0 && o_word_data[2:0] < 3'h3
        && o_word_data[5:3] < 3'h3 && o_word_data[8:6] < 3'h3 && o_word_data[11:9] < 3'h3)
        else $error("timing word holds a reserved code");
    a_smart_set: assert property (i_feat_set[0] |=> o_smart_enabled)
        else $error("smart enable not set");
    a_smart_clr: assert property (i_feat_clr[0] && !i_feat_set[0] && $past(i_rst_n) |=> !o_smart_enabled)
        else $error("smart enable not cleared");
endmodule

bind identify_capability_words identify_words_checker #(.MAX_UDMA_MODE(MAX_UDMA_MODE),
    .MAX_MDMA_MODE(MAX_MDMA_MODE), .UDMA_SUPPORTED(UDMA_SUPPORTED)) u_chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_word_rd(i_word_rd), .i_word_index(i_word_index),
    .o_word_data(o_word_data), .o_word_valid(o_word_valid), .o_word_mapped(o_word_mapped),
    .i_true_ide(i_true_ide), .i_feat_set(i_feat_set), .i_feat_clr(i_feat_clr), .i_smart_saved(i_smart_saved),
    .o_smart_enabled(o_smart_enabled), .i_mode_sel(i_mode_sel), .i_mode_kind(i_mode_kind),
    .i_mode_num(i_mode_num), .o_mode_reject(o_mode_reject));
`default_nettype wire

// ### bench/ata_host_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// host side: fetches one identify word per request
module ata_host_model (
    // clock
    input  wire logic        i_clock,
    // request towards the device
    output logic             o_word_rd,
    output logic [7:0]       o_word_index,
    // answer from the device
    input  wire logic [15:0] i_word_data,
    input  wire logic        i_word_valid
);
    initial begin
        o_word_rd    = 1'b0;
        o_word_index = 8'h00;
    end

    // gap idles the host first, so slow hosts are covered too
    task automatic fetch(input logic [7:0] ix, input int gap, output logic [15:0] d,
                         output logic nd, output logic ok);
        repeat (gap) @(posedge i_clock);
        @(posedge i_clock);
        #1;
        o_word_rd    = 1'b1;
        o_word_index = ix;
        @(posedge i_clock);
        #1;
        o_word_rd    = 1'b0;
        // idle index never repeats the last one
        o_word_index = ~ix;
        ok = (i_word_valid === 1'b1);
        d  = i_word_data;
        nd = (d === 16'h0000) || (d === 16'hFFFF);
    endtask
endmodule
`default_nettype wire

// ### bench/identify_capability_words_tb.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module identify_capability_words_tb;
    logic                           i_clock;
    logic                           i_rst_n;
    logic                           i_word_rd;
    logic [7:0]                     i_word_index;
    logic [15:0]                    o_word_data;
    logic                           o_word_valid;
    logic                           o_word_mapped;
    logic                           i_true_ide;
    logic [5:0]                     i_feat_set;
    logic [5:0]                     i_feat_clr;
    logic                           i_smart_saved;
    logic                           o_smart_enabled;
    logic                           i_mode_sel;
    identify_words_pkg::xfer_kind_t i_mode_kind;
    logic [2:0]                     i_mode_num;
    logic                           o_mode_reject;
    int                             fails;
    int                             n_tests;
    logic [15:0]                    rd_d;
    logic                           rd_nd;
    logic                           rd_ok;

    identify_capability_words DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_word_rd(i_word_rd),
        .i_word_index(i_word_index), .o_word_data(o_word_data), .o_word_valid(o_word_valid),
        .o_word_mapped(o_word_mapped), .i_true_ide(i_true_ide), .i_feat_set(i_feat_set),
        .i_feat_clr(i_feat_clr), .i_smart_saved(i_smart_saved), .o_smart_enabled(o_smart_enabled),
        .i_mode_sel(i_mode_sel), .i_mode_kind(i_mode_kind), .i_mode_num(i_mode_num),
        .o_mode_reject(o_mode_reject));
    ata_host_model host (.i_clock(i_clock), .o_word_rd(i_word_rd), .o_word_index(i_word_index),
        .i_word_data(o_word_data), .i_word_valid(o_word_valid));

    ////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] ix, input logic [15:0] exp);
        host.fetch(ix, 0, rd_d, rd_nd, rd_ok);
        check({15'h0000, rd_ok}, 16'h0001);
        check(rd_d, exp);
    endtask
    task automatic feat(input logic [5:0] set, input logic [5:0] clr);
        @(posedge i_clock);
        #1;
        i_feat_set = set;
        i_feat_clr = clr;
        @(posedge i_clock);
        #1;
        i_feat_set = 6'h00;
        i_feat_clr = 6'h00;
    endtask
    // reject is looked at in the one cycle that it stands
    task automatic pick(input logic [1:0] kind, input logic [2:0] num, input logic rej);
        @(posedge i_clock);
        #1;
        i_mode_sel  = 1'b1;
        i_mode_kind = identify_words_pkg::xfer_kind_t'(kind);
        i_mode_num  = num;
        @(posedge i_clock);
        #1;
        i_mode_sel = 1'b0;
        check({15'h0000, o_mode_reject}, {15'h0000, rej});
    endtask
    task automatic do_reset(input logic saved);
        @(posedge i_clock);
        #1;
        i_rst_n       = 1'b0;
        i_smart_saved = saved;
        repeat (2) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values;
        logic [7:0]  ix [10] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'hA0, 8'hA3, 8'h59};
        logic [15:0] ex [10] = '{16'h706B, 16'h400C, 16'h4000, 16'h7009, 16'h0004, 16'h4000,
                                 16'h001F, 16'h8064, 16'h0012, 16'h0000};
        for (int k = 0; k < 10; k++) begin
            rd_chk(ix[k], ex[k]);
        end
        check({15'h0000, o_word_mapped}, 16'h0000);
        check({15'h0000, o_smart_enabled}, 16'h0001);
    endtask
    task automatic t_feature_events;
        feat(6'h3E, 6'h00);
        rd_chk(8'h55, 16'h706B);
        rd_chk(8'h56, 16'h000C);
        rd_chk(8'hA0, 16'h9064);
        feat(6'h00, 6'h3F);
        rd_chk(8'h55, 16'h7008);
        rd_chk(8'h56, 16'h0004);
        rd_chk(8'hA0, 16'h8064);
        feat(6'h01, 6'h01);
        check({15'h0000, o_smart_enabled}, 16'h0001);
        feat(6'h00, 6'h01);
    endtask
    task automatic t_mode_select;
        pick(2'h2, 3'h2, 1'b0);
        rd_chk(8'h58, 16'h041F);
        pick(2'h1, 3'h4, 1'b0);
        rd_chk(8'h58, 16'h001F);
        rd_chk(8'hA3, 16'h0412);
        pick(2'h0, 3'h6, 1'b0);
        rd_chk(8'hA3, 16'h0492);
        pick(2'h0, 3'h5, 1'b0);
        rd_chk(8'hA3, 16'h0452);
        pick(2'h2, 3'h4, 1'b0);
        rd_chk(8'h58, 16'h101F);
        rd_chk(8'hA3, 16'h0052);
        pick(2'h2, 3'h5, 1'b1);
        pick(2'h1, 3'h5, 1'b1);
        pick(2'h3, 3'h0, 1'b1);
        rd_chk(8'h58, 16'h101F);
        i_true_ide = 1'b0;
        rd_chk(8'h58, 16'h0000);
        check({15'h0000, rd_nd}, 16'h0001);
        pick(2'h2, 3'h0, 1'b1);
        i_true_ide = 1'b1;
        rd_chk(8'h58, 16'h101F);
    endtask
    // smart enable comes back from the saved copy, modes do not
    task automatic t_power_cycle;
        do_reset(1'b0);
        host.fetch(8'h55, 5, rd_d, rd_nd, rd_ok);
        check(rd_d, 16'h7008);
        rd_chk(8'hA3, 16'h0012);
        do_reset(1'b1);
        host.fetch(8'h55, 3, rd_d, rd_nd, rd_ok);
        check(rd_d, 16'h7009);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // watchdog far beyond the roughly 115 cycles the run needs
    initial begin
        #50000;
        fails++;
        end_sim;
    end
    initial begin
        fails         = 0;
        n_tests       = 0;
        i_rst_n       = 1'b0;
        i_true_ide    = 1'b1;
        i_feat_set    = 6'h00;
        i_feat_clr    = 6'h00;
        i_smart_saved = 1'b1;
        i_mode_sel    = 1'b0;
        i_mode_kind   = identify_words_pkg::XFER_PIO;
        i_mode_num    = 3'h0;
        repeat (16) @(posedge i_clock);
        #1;
        i_rst_n = 1'b1;
        t_reset_values;
        t_feature_events;
        t_mode_select;
        t_power_cycle;
        end_sim;
    end
endmodule
`default_nettype wire
